// *** logic/sbba_pkg.sv ***
// package with constants and types for the sdram bank burst access block
// Operation
// - all inputs captured on rising clock edge
// - reads and writes run as stepped bursts
// - active takes bank bits and row bits
// - read/write address gives first burst column
// - burst lengths 1,2,4,8,page; terminate allowed
// - auto precharge closes row after burst
// - new column accepted every clock cycle
// - four banks, 4096 rows, 256 columns, 32 bits
// - one bank precharges while another is accessed
// - column is a[7:0], a[10] selects auto precharge
// - chip select high masks commands, bursts continue
package sbba_pkg;
  localparam int BANK_W = 2;
  localparam int ROW_W = 12;
  localparam int COL_W = 8;
  localparam int DATA_W = 32;
  localparam int NUM_BANKS = 4;
  localparam int AP_BIT = 10;
  localparam int CAS_LAT = 2;
  localparam int PRE_CYCLES = 2;
  localparam logic [COL_W:0] PAGE_LEN = 9'h100;
  localparam logic [2:0] BL_1 = 3'h0;
  localparam logic [2:0] BL_2 = 3'h1;
  localparam logic [2:0] BL_4 = 3'h2;
  localparam logic [2:0] BL_8 = 3'h3;
  localparam logic [2:0] BL_PAGE = 3'h7;

  typedef enum logic [2:0] {
    SBBA_CMD_NOP,
    SBBA_CMD_ACTIVE,
    SBBA_CMD_READ,
    SBBA_CMD_WRITE,
    SBBA_CMD_PRECHARGE,
    SBBA_CMD_TERMINATE,
    SBBA_CMD_OTHER
  } sbba_cmd_t;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [BANK_W-1:0] ba;
    logic [ROW_W-1:0] a;
  } sbba_cmd_bus_t;

  typedef struct packed {
    logic [DATA_W-1:0] rd_data;
    logic rd_valid;
    logic dq_oe;
  } sbba_data_out_t;
endpackage

// *** logic/sbba_bank.sv ***
// one bank: open row, row state and self-timed precharge
`timescale 1ns/1ps
module sbba_bank #(
  parameter int ROW_W = 12,
  parameter int PRE_W = 2,
  parameter logic [PRE_W-1:0] PRE_CYCLES = 2'h2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic activate,
  input wire logic [ROW_W-1:0] row_in,
  input wire logic precharge,
  output logic row_open,
  output logic [ROW_W-1:0] open_row
);
  typedef struct packed {
    logic open;
    logic [ROW_W-1:0] row;
    logic [PRE_W-1:0] pre_cnt;
  } sbba_bank_state_t;

  sbba_bank_state_t state_reg;
  sbba_bank_state_t state_next;

  always_comb
  begin
    state_next = state_reg;
    if (state_reg.pre_cnt != '0)
    begin
      state_next.pre_cnt = state_reg.pre_cnt - 1'b1;
    end
    if (precharge)
    begin
      // precharge runs per bank, independent of the others
      state_next.open = 1'b0;
      state_next.pre_cnt = PRE_CYCLES;
    end
    else if (activate && state_reg.pre_cnt == '0)
    begin
      // a bank still precharging refuses activation
      state_next.open = 1'b1;
      state_next.row = row_in;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign row_open = state_reg.open;
  assign open_row = state_reg.row;
endmodule // sbba_bank

// *** logic/sbba_core.sv ***
// sdram bank burst access core: command decode, banks, burst engine and array
`timescale 1ns/1ps
module sbba_core #(
  parameter int ROWS = 4096,
  parameter int COLS = 256,
  parameter int MEM_ROWS = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire sbba_pkg::sbba_cmd_bus_t cmd_in,
  input wire logic [2:0] burst_count_setting,
  input wire logic [sbba_pkg::DATA_W-1:0] wr_data,
  input wire logic [3:0] dqm,
  output sbba_pkg::sbba_data_out_t data_out,
  output logic [sbba_pkg::NUM_BANKS-1:0] bank_open
);
  localparam int BW = sbba_pkg::BANK_W;
  localparam int RW = sbba_pkg::ROW_W;
  localparam int CW = sbba_pkg::COL_W;
  localparam int DW = sbba_pkg::DATA_W;
  localparam int NB = sbba_pkg::NUM_BANKS;
  localparam int MRW = $clog2(MEM_ROWS);
  localparam int CL = sbba_pkg::CAS_LAT;

  typedef struct packed {
    logic active;
    logic is_write;
    logic auto_pre;
    logic [BW-1:0] bank;
    logic [CW-1:0] col;
    logic [CW:0] left;
    logic [CL-1:0] rd_pipe_v;
    logic [CL-1:0][DW-1:0] rd_pipe_d;
    sbba_pkg::sbba_data_out_t out;
  } sbba_core_state_t;

  sbba_core_state_t state_reg;
  sbba_core_state_t state_next;
  sbba_pkg::sbba_cmd_t cmd;
  logic [NB-1:0] act_vec;
  logic [NB-1:0] pre_vec;
  logic [NB-1:0] open_vec;
  logic [NB-1:0][RW-1:0] open_rows;
  // storage folded over a small number of row slots per bank
  logic [DW-1:0] mem_reg [NB*MEM_ROWS*COLS];
  logic mem_we;
  logic [$clog2(NB*MEM_ROWS*COLS)-1:0] mem_idx;
  logic [$clog2(NB*MEM_ROWS*COLS)-1:0] rd_idx;
  logic [CW:0] burst_len;
  logic [DW-1:0] wr_merged;
  logic [BW-1:0] cur_bank;
  logic [CW-1:0] cur_col;
  logic cur_valid;

  // command decode; chip select high masks every command
  always_comb
  begin
    cmd = sbba_pkg::SBBA_CMD_NOP;
    if (!cmd_in.cs_n)
    begin
      case ({cmd_in.ras_n, cmd_in.cas_n, cmd_in.we_n})
        3'b011: cmd = sbba_pkg::SBBA_CMD_ACTIVE;
        3'b101: cmd = sbba_pkg::SBBA_CMD_READ;
        3'b100: cmd = sbba_pkg::SBBA_CMD_WRITE;
        3'b010: cmd = sbba_pkg::SBBA_CMD_PRECHARGE;
        3'b110: cmd = sbba_pkg::SBBA_CMD_TERMINATE;
        3'b111: cmd = sbba_pkg::SBBA_CMD_NOP;
        default: cmd = sbba_pkg::SBBA_CMD_OTHER;
      endcase
    end
  end

  always_comb
  begin
    case (burst_count_setting)
      sbba_pkg::BL_1: burst_len = 9'h001;
      sbba_pkg::BL_2: burst_len = 9'h002;
      sbba_pkg::BL_4: burst_len = 9'h004;
      sbba_pkg::BL_8: burst_len = 9'h008;
      sbba_pkg::BL_PAGE: burst_len = sbba_pkg::PAGE_LEN;
      default: burst_len = 9'h001;
    endcase
  end

  // a read or write starts a new burst at once, cutting any running one
  always_comb
  begin
    cur_valid = 1'b0;
    cur_bank = state_reg.bank;
    cur_col = state_reg.col;
    if (cmd == sbba_pkg::SBBA_CMD_READ || cmd == sbba_pkg::SBBA_CMD_WRITE)
    begin
      cur_valid = 1'b1;
      cur_bank = cmd_in.ba;
      cur_col = cmd_in.a[CW-1:0];
    end
    else if (state_reg.active && cmd != sbba_pkg::SBBA_CMD_TERMINATE)
    begin
      cur_valid = 1'b1;
    end
  end

  always_comb
  begin
    state_next = state_reg;
    pre_vec = '0;
    act_vec = '0;
    mem_we = 1'b0;
    state_next.rd_pipe_v = {state_reg.rd_pipe_v[CL-2:0], 1'b0};
    state_next.rd_pipe_d = {state_reg.rd_pipe_d[CL-2:0], mem_reg[rd_idx]};
    state_next.out.rd_valid = state_reg.rd_pipe_v[CL-1];
    state_next.out.rd_data = state_reg.rd_pipe_d[CL-1];
    state_next.out.dq_oe = state_reg.rd_pipe_v[CL-1];
    if (cmd == sbba_pkg::SBBA_CMD_ACTIVE)
    begin
      act_vec[cmd_in.ba] = 1'b1;
    end
    if (cmd == sbba_pkg::SBBA_CMD_PRECHARGE)
    begin
      if (cmd_in.a[sbba_pkg::AP_BIT])
      begin
        pre_vec = '1;
      end
      else
      begin
        pre_vec[cmd_in.ba] = 1'b1;
      end
    end
    if (cmd == sbba_pkg::SBBA_CMD_TERMINATE)
    begin
      state_next.active = 1'b0;
      if (state_reg.active && state_reg.auto_pre)
      begin
        pre_vec[state_reg.bank] = 1'b1;
      end
    end
    if (cmd == sbba_pkg::SBBA_CMD_READ || cmd == sbba_pkg::SBBA_CMD_WRITE)
    begin
      if (state_reg.active && state_reg.auto_pre && state_reg.bank != cmd_in.ba)
      begin
        pre_vec[state_reg.bank] = 1'b1;
      end
      state_next.is_write = (cmd == sbba_pkg::SBBA_CMD_WRITE);
      state_next.auto_pre = cmd_in.a[sbba_pkg::AP_BIT];
      state_next.bank = cmd_in.ba;
      state_next.col = cmd_in.a[CW-1:0];
      state_next.left = burst_len;
      state_next.active = 1'b1;
    end
    if (cur_valid)
    begin
      if (cmd == sbba_pkg::SBBA_CMD_WRITE || (cmd != sbba_pkg::SBBA_CMD_READ && state_reg.is_write))
      begin
        mem_we = open_vec[cur_bank];
      end
      else
      begin
        state_next.rd_pipe_v[0] = open_vec[cur_bank];
      end
      // sequential stepping, wrapping inside the burst-aligned block
      state_next.col = cur_col + 1'b1;
      if (burst_len != sbba_pkg::PAGE_LEN)
      begin
        state_next.col = (cur_col & ~CW'(burst_len - 1'b1)) | (CW'(cur_col + 1'b1) & CW'(burst_len - 1'b1));
      end
      state_next.left = ((cmd == sbba_pkg::SBBA_CMD_READ || cmd == sbba_pkg::SBBA_CMD_WRITE) ? burst_len
                         : state_reg.left) - 1'b1;
      if (state_next.left == '0 && burst_len != sbba_pkg::PAGE_LEN)
      begin
        state_next.active = 1'b0;
        if (state_next.auto_pre)
        begin
          pre_vec[cur_bank] = 1'b1;
        end
      end
      else if (burst_len == sbba_pkg::PAGE_LEN)
      begin
        state_next.left = sbba_pkg::PAGE_LEN;
      end
    end
  end

  assign rd_idx = {cur_bank, open_rows[cur_bank][MRW-1:0], cur_col};
  assign mem_idx = rd_idx;

  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      wr_merged[i*8 +: 8] = dqm[i] ? mem_reg[mem_idx][i*8 +: 8] : wr_data[i*8 +: 8];
    end
  end

  for (genvar b = 0; b < NB; b++)
  begin : g_bank
    sbba_bank #(
      .ROW_W(RW),
      .PRE_W(2),
      .PRE_CYCLES(2'(sbba_pkg::PRE_CYCLES))
    ) u_bank (
      .clk(clk),
      .rst(rst),
      .activate(act_vec[b]),
      .row_in(cmd_in.a),
      .precharge(pre_vec[b]),
      .row_open(open_vec[b]),
      .open_row(open_rows[b])
    );
  end

  always_ff @(posedge clk)
  begin
    if (mem_we)
    begin
      mem_reg[mem_idx] <= wr_merged;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_reg <= '0;
      bank_open <= '0;
    end
    else
    begin
      state_reg <= state_next;
      bank_open <= open_vec;
    end
  end

  assign data_out = state_reg.out;
endmodule // sbba_core

// *** test/sbba_core_asserts.sv ***
// concurrent checks on the sdram bank burst access core ports
`timescale 1ns/1ps
module sbba_core_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire sbba_pkg::sbba_cmd_bus_t cmd_in,
  input wire logic [2:0] burst_count_setting,
  input wire logic [sbba_pkg::DATA_W-1:0] wr_data,
  input wire logic [3:0] dqm,
  input wire sbba_pkg::sbba_data_out_t data_out,
  input wire logic [sbba_pkg::NUM_BANKS-1:0] bank_open
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire logic [2:0] op = cmd_in.cs_n ? 3'h7 : {cmd_in.ras_n, cmd_in.cas_n, cmd_in.we_n};
  wire logic act = op == 3'h3;
  wire logic rd_ok = op == 3'h5 && bank_open[cmd_in.ba];
  wire logic [2:0] bcs = burst_count_setting;

  reset_quiet_a: assert property (disable iff (1'b0) rst |=> !data_out.rd_valid && bank_open == '0)
    else $error("outputs not quiet after reset");
  oe_match_a: assert property (data_out.dq_oe == data_out.rd_valid)
    else $error("output enable differs from read valid");
  read_latency_a: assert property (rd_ok ##1 op != 3'h6 |-> ##2 data_out.rd_valid)
    else $error("read word late or missing");
  active_opens_a: assert property (act ##1 op != 3'h2 |-> ##1 bank_open[$past(cmd_in.ba, 2)])
    else $error("active did not open bank");
  no_stray_open_a: assert property ((bank_open & ~$past(bank_open)) != '0 |-> $past(act, 2))
    else $error("bank opened without active");
  single_burst_a: assert property (rd_ok && bcs == 3'h0 ##1 cmd_in.cs_n [*3] |-> data_out.rd_valid ##1 !data_out.rd_valid)
    else $error("single burst length wrong");
  quad_burst_a: assert property (rd_ok && bcs == 3'h2 ##1 cmd_in.cs_n [*7]
    |-> !data_out.rd_valid && $past(data_out.rd_valid) && $past(data_out.rd_valid, 4) && !$past(data_out.rd_valid, 5))
    else $error("four word burst length wrong");
  auto_close_a: assert property (rd_ok && cmd_in.a[10] && bcs == 3'h0 ##1 cmd_in.cs_n [*8]
    |-> !bank_open[$past(cmd_in.ba, 8)])
    else $error("auto precharge left row open");
endmodule // sbba_core_asserts

// *** test/sbba_ctrl_model.sv ***
// memory controller model: forwards commands, deselects with junk lines when idle
`timescale 1ns/1ps
module sbba_ctrl_model (
  input wire logic clk,
  input wire logic go,
  input wire sbba_pkg::sbba_cmd_bus_t req,
  output sbba_pkg::sbba_cmd_bus_t cmd_out
);
  sbba_pkg::sbba_cmd_bus_t idle_reg = '0;
  // idle lines flip every cycle so a masked command never looks stable
  always_ff @(posedge clk) idle_reg <= ~cmd_out;
  // bench orders active before access, except the t_autopre read of the closed bank 1, and precharge before reopening; no self refresh is ever sent
  assign cmd_out = go ? req : (idle_reg | 18'h2_0000);
endmodule // sbba_ctrl_model

// *** test/sbba_core_test.sv ***
// self-checking bench for the sdram bank burst access core
`timescale 1ns/1ps
module sbba_core_test;
  logic clk = 0, rst = 1, go = 0;
  logic [2:0] bcs = 3'h2;
  logic [31:0] wr_data = '0;
  logic [3:0] dqm = '0;
  logic [3:0] bank_open;
  sbba_pkg::sbba_cmd_bus_t req = '0, cmd_in;
  sbba_pkg::sbba_data_out_t data_out;
  logic [31:0] got[$], exp[$];
  int fail_count = 0, n_compared = 0, cyc = 0;
  sbba_ctrl_model partner (.clk(clk), .go(go), .req(req), .cmd_out(cmd_in));
  sbba_core dut (.clk(clk), .rst(rst), .cmd_in(cmd_in), .burst_count_setting(bcs), .wr_data(wr_data),
    .dqm(dqm), .data_out(data_out), .bank_open(bank_open));
  initial forever #50 clk = ~clk;
  always @(posedge clk) if (data_out.rd_valid === 1'b1) got.push_back(data_out.rd_data);
  task automatic end_sim;
    if (fail_count == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 1000)
    begin
      fail_count++;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // c is {ras_n, cas_n, we_n}; v low sends a deselect
  task automatic cmd(input logic [2:0] c, input logic [1:0] b, input logic [11:0] ad, input logic v = 1'b1);
    go <= v;
    req <= '{cs_n: 1'b0, ras_n: c[2], cas_n: c[1], we_n: c[0], ba: b, a: ad};
    @(posedge clk);
  endtask
  task automatic drain(input int n);
    repeat (12) cmd(3'h7, 2'h0, 12'h000, 1'b0);
    chk(32'(got.size()), 32'(n));
    foreach (exp[i]) chk(got[i], exp[i]);
    got.delete();
    exp.delete();
  endtask
  task automatic t_wrap;
    cmd(3'h3, 2'h1, 12'h005);
    for (int i = 0; i < 4; i++)
    begin
      wr_data <= 32'h5a5a_0000 + 32'(i);
      cmd(3'h4, 2'h1, 12'h0fe, i == 0);
    end
    exp = '{32'h5a5a_0002, 32'h5a5a_0003, 32'h5a5a_0000, 32'h5a5a_0001};
    cmd(3'h5, 2'h1, 12'h0fc);
    drain(4);
  endtask
  // back-to-back reads at new columns, each cutting the one before
  task automatic t_random;
    bcs <= 3'h1;
    cmd(3'h5, 2'h1, 12'h0fd);
    cmd(3'h5, 2'h1, 12'h0fc);
    cmd(3'h5, 2'h1, 12'h0ff);
    exp = '{32'h5a5a_0003, 32'h5a5a_0002, 32'h5a5a_0001, 32'h5a5a_0000};
    drain(4);
  endtask
  // byte mask still applies on a burst word written while deselected
  task automatic t_mask;
    logic [31:0] wd[4] = '{32'h1111_1111, 32'h2222_2222, 32'haaaa_aaaa, 32'hbbbb_bbbb};
    bcs <= 3'h1;
    for (int i = 0; i < 4; i++)
    begin
      wr_data <= wd[i];
      dqm <= (i == 3) ? 4'h5 : 4'h0;
      cmd(3'h4, 2'h1, 12'h010, i % 2 == 0);
    end
    dqm <= 4'h0;
    exp = '{32'haaaa_aaaa, 32'hbb22_bb22};
    cmd(3'h5, 2'h1, 12'h010);
    drain(2);
  endtask
  task automatic t_lengths;
    logic [2:0] codes[5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5};
    int lens[5] = '{1, 2, 4, 8, 1};
    for (int k = 0; k < 5; k++)
    begin
      bcs <= codes[k];
      cmd(3'h5, 2'h1, 12'h000);
      drain(lens[k]);
    end
  endtask
  task automatic t_page;
    bcs <= 3'h7;
    cmd(3'h5, 2'h1, 12'h000);
    repeat (20) cmd(3'h7, 2'h0, 12'h000, 1'b0);
    chk({31'h0, data_out.rd_valid}, 32'h1);
    cmd(3'h6, 2'h1, 12'h000);
    repeat (6) cmd(3'h7, 2'h0, 12'h000, 1'b0);
    chk({31'h0, data_out.rd_valid}, 32'h0);
    got.delete();
  endtask
  task automatic t_autopre;
    bcs <= 3'h0;
    cmd(3'h3, 2'h2, 12'h003);
    cmd(3'h5, 2'h1, 12'h400);
    drain(1);
    chk({28'h0, bank_open}, 32'h4);
    cmd(3'h5, 2'h1, 12'h000);
    drain(0);
    cmd(3'h2, 2'h0, 12'h400);
    repeat (4) cmd(3'h7, 2'h0, 12'h000, 1'b0);
    chk({28'h0, bank_open}, 32'h0);
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 0;
    t_wrap();
    t_random();
    t_mask();
    t_lengths();
    t_page();
    t_autopre();
    end_sim();
  end
endmodule // sbba_core_test
bind sbba_core sbba_core_asserts chk_u (.clk(clk), .rst(rst), .cmd_in(cmd_in), .burst_count_setting(burst_count_setting),
  .wr_data(wr_data), .dqm(dqm), .data_out(data_out), .bank_open(bank_open));
